// File: osc_octal_xcvr.sv
`timescale 1ns/1ps
`include "osc_cfg.svh"
// Contract
// - register changes only on the rising clock edge.
// - register can capture a word from either the A or B bus.
// - register drives A (outside the add modes) or B independently while that enable is low.
// - both enables high leaves both buses undriven.
// - add mode with carry: register gets A plus register plus carry.
// - add mode without carry: register gets A plus register.
// - gated count increments when the gate input is high.
// - gated count holds when the gate input is low.
// - free count increments on every edge.
// - shift takes the serial bit in; status shows the top bit.
// - load A captures A when the A enable is high.
// - load B captures B when the B enable is high.
// - load from a port being driven keeps the register and drives it.
// - hold keeps the register; status shows parity.
// - parity over all eight register bits is computed continuously.
// - terminal count is high exactly when all bits are one.
// - parity is high for an odd number of ones.
module osc_octal_xcvr #(
  parameter int WIDTH = `OSC_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic master_clear_n,
  input wire osc_pkg::osc_sel_t sel,
  input wire logic carry_serial_gate_in,
  input wire logic a_oe_n,
  input wire logic b_oe_n,
  // a bus
  input wire logic [WIDTH-1:0] a_in,
  output logic [WIDTH-1:0] a_out,
  output logic a_oe,
  // b bus
  input wire logic [WIDTH-1:0] b_in,
  output logic [WIDTH-1:0] b_out,
  output logic b_oe,
  // status
  output logic status_output
);
  osc_pkg::osc_state_t st_q;
  osc_pkg::osc_state_t st_d;
  logic [WIDTH:0] sum;
  logic carry_in;
  logic add_mode;
  osc_pkg::osc_drive_t a_drv;
  osc_pkg::osc_drive_t b_drv;

  // adder sees the carry only in the carry mode
  assign add_mode = (sel == osc_pkg::OSC_ADD_CI) || (sel == osc_pkg::OSC_ADD_NC);
  assign carry_in = (sel == osc_pkg::OSC_ADD_CI) ? carry_serial_gate_in : 1'b0;
  assign sum = {1'b0, a_in} + {1'b0, st_q.q} + {{WIDTH{1'b0}}, carry_in};

  // next register value by operation
  always_comb begin
    st_d = st_q;
    if (!master_clear_n) begin
      st_d.q = `OSC_RST_VAL;
    end else begin
      case (sel)
        osc_pkg::OSC_ADD_CI, osc_pkg::OSC_ADD_NC: st_d.q = sum[WIDTH-1:0];
        osc_pkg::OSC_CNT_GATE: begin
          if (carry_serial_gate_in) begin
            st_d.q = st_q.q + `OSC_ONE;
          end else begin
            st_d.q = st_q.q;
          end
        end
        osc_pkg::OSC_CNT: st_d.q = st_q.q + `OSC_ONE;
        osc_pkg::OSC_SHIFT: st_d.q = {st_q.q[WIDTH-2:0], carry_serial_gate_in};
        osc_pkg::OSC_LOAD_A: begin
          // a port being driven by us cannot be sampled, so keep
          if (a_oe_n) begin
            st_d.q = a_in;
          end else begin
            st_d.q = st_q.q;
          end
        end
        osc_pkg::OSC_LOAD_B: begin
          if (b_oe_n) begin
            st_d.q = b_in;
          end else begin
            st_d.q = st_q.q;
          end
        end
        default: st_d.q = st_q.q;
      endcase
    end
  end

  // the only storage, updated on the rising edge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q.q <= `OSC_RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  // bus drivers; a is an input during add so the register goes out on b only
  always_comb begin
    a_drv.oe = !a_oe_n && !add_mode;
    b_drv.oe = !b_oe_n;
    a_drv.dout = master_clear_n ? st_q.q : `OSC_RST_VAL;
    b_drv.dout = master_clear_n ? st_q.q : `OSC_RST_VAL;
  end
  assign a_out = a_drv.dout;
  assign a_oe = a_drv.oe;
  assign b_out = b_drv.dout;
  assign b_oe = b_drv.oe;

  // carry out of the live adder, the status mux picks it in add modes
  osc_status #(
    .WIDTH(WIDTH)
  ) u_status (
    .sel(sel),
    .q(st_q.q),
    .carry_out(sum[WIDTH]),
    .master_clear_n(master_clear_n),
    .status_output(status_output)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // expected sums are rebuilt from the operands, not read off the adder net
  property p_add_ci;
    master_clear_n && sel == osc_pkg::OSC_ADD_CI
      |=> st_q.q == $past(a_in + st_q.q + {{(WIDTH-1){1'b0}}, carry_serial_gate_in});
  endproperty
  a_add_ci: assert property (p_add_ci) else $error("add with carry wrong");

  property p_add_nc_carry;
    master_clear_n && sel == osc_pkg::OSC_ADD_NC
      |-> status_output == (({1'b0, a_in} + {1'b0, st_q.q}) > {1'b0, `OSC_TC_VAL});
  endproperty
  a_add_nc_carry: assert property (p_add_nc_carry) else $error("carry out wrong");

  property p_gate_hold;
    master_clear_n && sel == osc_pkg::OSC_CNT_GATE && !carry_serial_gate_in |=> $stable(st_q.q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");

  property p_count;
    master_clear_n && sel == osc_pkg::OSC_CNT |=> st_q.q == $past(st_q.q) + `OSC_ONE;
  endproperty
  a_count: assert property (p_count) else $error("count wrong");

  property p_shift;
    master_clear_n && sel == osc_pkg::OSC_SHIFT
      |=> st_q.q[0] == $past(carry_serial_gate_in) && st_q.q[WIDTH-1] == $past(st_q.q[WIDTH-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_load_a_busy;
    master_clear_n && sel == osc_pkg::OSC_LOAD_A && !a_oe_n |-> a_oe ##1 $stable(st_q.q);
  endproperty
  a_load_a_busy: assert property (p_load_a_busy) else $error("driven port captured");

  property p_load_b;
    master_clear_n && sel == osc_pkg::OSC_LOAD_B && b_oe_n |=> st_q.q == $past(b_in);
  endproperty
  a_load_b: assert property (p_load_b) else $error("load b wrong");

  property p_tc;
    master_clear_n && sel == osc_pkg::OSC_CNT |-> status_output == (st_q.q == `OSC_TC_VAL);
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count wrong");

  property p_parity;
    master_clear_n && sel == osc_pkg::OSC_HOLD |-> status_output == ^st_q.q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");

  property p_clear;
    !master_clear_n |-> !status_output && a_out == `OSC_RST_VAL ##1 st_q.q == `OSC_RST_VAL;
  endproperty
  a_clear: assert property (p_clear) else $error("clear incomplete");

  property p_tristate;
    a_oe_n && b_oe_n |-> !a_oe && !b_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("bus driven while disabled");

  property p_gate_count;
    master_clear_n && sel == osc_pkg::OSC_CNT_GATE && carry_serial_gate_in
      |=> st_q.q == $past(st_q.q) + `OSC_ONE;
  endproperty
  a_gate_count: assert property (p_gate_count) else $error("gated count did not step");

  property p_load_a;
    master_clear_n && sel == osc_pkg::OSC_LOAD_A && a_oe_n |=> st_q.q == $past(a_in);
  endproperty
  a_load_a: assert property (p_load_a) else $error("load a wrong");

  property p_load_b_busy;
    master_clear_n && sel == osc_pkg::OSC_LOAD_B && !b_oe_n |-> b_oe ##1 $stable(st_q.q);
  endproperty
  a_load_b_busy: assert property (p_load_b_busy) else $error("driven b port captured");

  property p_shift_status;
    master_clear_n && sel == osc_pkg::OSC_SHIFT |-> status_output == st_q.q[WIDTH-1];
  endproperty
  a_shift_status: assert property (p_shift_status) else $error("shift status wrong");

  // a is the addend in add modes, so only the other modes may drive it
  property p_drive_a;
    master_clear_n && !a_oe_n && sel != osc_pkg::OSC_ADD_CI && sel != osc_pkg::OSC_ADD_NC
      |-> a_oe && a_out == st_q.q;
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("a bus not driven");

  property p_drive_b;
    master_clear_n && !b_oe_n |-> b_oe && b_out == st_q.q;
  endproperty
  a_drive_b: assert property (p_drive_b) else $error("b bus not driven");

  c_wrap: cover property (master_clear_n && sel == osc_pkg::OSC_CNT && st_q.q == `OSC_TC_VAL);
  c_carry: cover property (master_clear_n && add_mode && sum[WIDTH]);
  c_load_a: cover property (master_clear_n && sel == osc_pkg::OSC_LOAD_A && a_oe_n && !b_oe_n);
  c_shift_top: cover property (master_clear_n && sel == osc_pkg::OSC_SHIFT && st_q.q[WIDTH-1]);
  c_load_b_busy: cover property (master_clear_n && sel == osc_pkg::OSC_LOAD_B && !b_oe_n);
endmodule : osc_octal_xcvr

// File: osc_cfg.svh
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// register width and values
`define OSC_WIDTH 8
`define OSC_RST_VAL 8'h00
`define OSC_TC_VAL 8'hff
`define OSC_ONE 8'h01
// operation select codes, first select pin is the msb
`define OSC_SEL_ADD_CI 3'h0
`define OSC_SEL_ADD_NC 3'h1
`define OSC_SEL_CNT_GATE 3'h2
`define OSC_SEL_CNT 3'h3
`define OSC_SEL_SHIFT 3'h4
`define OSC_SEL_LOAD_A 3'h5
`define OSC_SEL_LOAD_B 3'h6
`define OSC_SEL_HOLD 3'h7
`endif

// File: osc_pkg.sv
`include "osc_cfg.svh"
package osc_pkg;
  typedef enum logic [2:0] {
    OSC_ADD_CI = `OSC_SEL_ADD_CI,
    OSC_ADD_NC = `OSC_SEL_ADD_NC,
    OSC_CNT_GATE = `OSC_SEL_CNT_GATE,
    OSC_CNT = `OSC_SEL_CNT,
    OSC_SHIFT = `OSC_SEL_SHIFT,
    OSC_LOAD_A = `OSC_SEL_LOAD_A,
    OSC_LOAD_B = `OSC_SEL_LOAD_B,
    OSC_HOLD = `OSC_SEL_HOLD
  } osc_sel_t;

  // whole state of the transceiver
  typedef struct packed {
    logic [`OSC_WIDTH-1:0] q;
  } osc_state_t;

  // one two-way bus as seen by the design
  typedef struct packed {
    logic [`OSC_WIDTH-1:0] dout;
    logic oe;
  } osc_drive_t;
endpackage : osc_pkg

// File: osc_status.sv
`timescale 1ns/1ps
`include "osc_cfg.svh"
module osc_status #(
  parameter int WIDTH = `OSC_WIDTH
) (
  // inputs
  input wire osc_pkg::osc_sel_t sel,
  input wire logic [WIDTH-1:0] q,
  input wire logic carry_out,
  input wire logic master_clear_n,
  // result
  output logic status_output
);
  logic parity;
  logic terminal_count;

  // odd parity and all-ones detect, both purely combinational
  assign parity = ^q;
  assign terminal_count = &q;

  // status source follows the operation; clear forces it low
  always_comb begin
    status_output = 1'b0;
    if (master_clear_n) begin
      case (sel)
        osc_pkg::OSC_ADD_CI, osc_pkg::OSC_ADD_NC: status_output = carry_out;
        osc_pkg::OSC_CNT_GATE, osc_pkg::OSC_CNT: status_output = terminal_count;
        osc_pkg::OSC_SHIFT: status_output = q[WIDTH-1];
        default: status_output = parity;
      endcase
    end
  end
endmodule : osc_status

// File: osc_bus_model.sv
`timescale 1ns/1ps
`include "osc_cfg.svh"
module osc_bus_model (
  // device side of both buses
  input wire logic [`OSC_WIDTH-1:0] a_out,
  input wire logic a_oe,
  input wire logic [`OSC_WIDTH-1:0] b_out,
  input wire logic b_oe,
  // words the far logic offers when the bus is free
  input wire logic [`OSC_WIDTH-1:0] a_ext,
  input wire logic [`OSC_WIDTH-1:0] b_ext,
  // resolved bus levels seen at the pins
  output logic [`OSC_WIDTH-1:0] a_in,
  output logic [`OSC_WIDTH-1:0] b_in
);
  // far logic backs off while the device drives, so no contention is modelled
  assign a_in = a_oe ? a_out : a_ext;
  assign b_in = b_oe ? b_out : b_ext;
endmodule : osc_bus_model

// File: osc_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb;
  logic ref_clk, reset_n, master_clear_n, ci, a_oe_n, b_oe_n, a_oe, b_oe, status_output;
  osc_pkg::osc_sel_t sel;
  logic [7:0] a_in, b_in, a_out, b_out, a_v, b_v;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  osc_octal_xcvr i_osc_octal_xcvr (.ref_clk(ref_clk), .reset_n(reset_n),
    .master_clear_n(master_clear_n), .sel(sel), .carry_serial_gate_in(ci),
    .a_oe_n(a_oe_n), .b_oe_n(b_oe_n), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
    .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .status_output(status_output));
  osc_bus_model i_osc_bus_model (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .a_ext(a_v), .b_ext(b_v), .a_in(a_in), .b_in(b_in));
  // free running clock, 40 ns period
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard; the whole run needs only a few dozen cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // apply one operation; the edge of the next call executes it
  task automatic go(input osc_pkg::osc_sel_t s, input logic c, an, bn,
                    input logic [7:0] av, bv);
    @(posedge ref_clk);
    sel <= s;
    ci <= c;
    a_oe_n <= an;
    b_oe_n <= bn;
    a_v <= av;
    b_v <= bv;
    #1;
  endtask : go
  task automatic t_reset();
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h0, 1'h0, 8'h5a, 8'h5a);
    `CHK("a_out", 8'h00, a_out)
    `CHK("b_out", 8'h00, b_out)
  endtask : t_reset
  task automatic t_load_add();
    go(osc_pkg::OSC_LOAD_A, 1'h0, 1'h1, 1'h0, 8'ha4, 8'h00);
    go(osc_pkg::OSC_ADD_CI, 1'h1, 1'h0, 1'h0, 8'h7f, 8'h00);
    `CHK("a_oe", 1'h0, a_oe)
    `CHK("b_out", 8'ha4, b_out)
    `CHK("carry", 1'h1, status_output)
    go(osc_pkg::OSC_ADD_NC, 1'h1, 1'h1, 1'h0, 8'hdc, 8'h00);
    `CHK("b_out", 8'h24, b_out)
    `CHK("carry", 1'h1, status_output)
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h1, 1'h0, 8'h00, 8'h00);
    `CHK("b_out", 8'h00, b_out)
    `CHK("a_oe", 1'h0, a_oe)
  endtask : t_load_add
  task automatic t_count_shift();
    go(osc_pkg::OSC_LOAD_B, 1'h0, 1'h0, 1'h1, 8'h00, 8'hfe);
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'hfe, a_out)
    `CHK("parity", 1'h1, status_output)
    go(osc_pkg::OSC_CNT, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("tc", 1'h0, status_output)
    go(osc_pkg::OSC_CNT_GATE, 1'h1, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'hff, a_out)
    `CHK("tc", 1'h1, status_output)
    go(osc_pkg::OSC_CNT_GATE, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h00, a_out)
    go(osc_pkg::OSC_SHIFT, 1'h1, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h00, a_out)
    go(osc_pkg::OSC_SHIFT, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h01, a_out)
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h02, a_out)
    go(osc_pkg::OSC_LOAD_B, 1'h0, 1'h0, 1'h1, 8'h00, 8'h81);
    go(osc_pkg::OSC_SHIFT, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h81, a_out)
    `CHK("top bit", 1'h1, status_output)
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h02, a_out)
  endtask : t_count_shift
  task automatic t_refuse();
    go(osc_pkg::OSC_LOAD_A, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00);
    `CHK("a_oe", 1'h1, a_oe)
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h1, 1'h1, 8'h77, 8'h77);
    `CHK("b_out", 8'h02, b_out)
    `CHK("a_oe", 1'h0, a_oe)
    `CHK("b_oe", 1'h0, b_oe)
    `CHK("parity", 1'h1, status_output)
    go(osc_pkg::OSC_LOAD_B, 1'h0, 1'h1, 1'h0, 8'h00, 8'h3c);
    `CHK("b_oe", 1'h1, b_oe)
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h1, 1'h1, 8'h00, 8'h00);
    `CHK("a_out", 8'h02, a_out)
  endtask : t_refuse
  task automatic t_clear();
    go(osc_pkg::OSC_HOLD, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00);
    @(posedge ref_clk);
    master_clear_n <= 1'h0;
    #1;
    `CHK("a_out", 8'h00, a_out)
    `CHK("status", 1'h0, status_output)
    @(posedge ref_clk);
    master_clear_n <= 1'h1;
    #1;
    `CHK("b_out", 8'h00, b_out)
    `CHK("parity", 1'h0, status_output)
  endtask : t_clear
  // reset held for four cycles, then the scenarios in turn
  initial begin
    reset_n = 1'h0;
    master_clear_n = 1'h1;
    sel = osc_pkg::OSC_HOLD;
    ci = 1'h0;
    a_oe_n = 1'h1;
    b_oe_n = 1'h1;
    a_v = 8'h00;
    b_v = 8'h00;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_reset();
    t_load_add();
    t_count_shift();
    t_refuse();
    t_clear();
    repeat (2) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : tb
